// ==== shifter_params.svh ====
// Operation
// - right shift by count, carry gets last out
// - right shift fills upper count bits zero
// - right output follows result least bit
// - left shift by count, carry gets last out
// - left shift fills lower count bits zero
// - left output follows result most bit
// - enabled shift moves table toward higher address
// - data input loads lowest table bit
// - bit leaving top of table enters carry
// - enable low clears table and carry
// - enable low holds table output low
// - enabled table output shows last bit
// - enabled without shift leaves table unchanged
// - one shift per scan while shift high
`ifndef SHIFTER_PARAMS_SVH
`define SHIFTER_PARAMS_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_SRC 8'h04
`define OFS_COUNT 8'h08
`define OFS_LEN 8'h0C
`define OFS_SCAN 8'h10
`define OFS_STATUS 8'h14
`define OFS_DEST_R 8'h18
`define OFS_DEST_L 8'h1C
`define OFS_TAB_LO 8'h20
`define OFS_TAB_HI 8'h24

// control field positions
`define CTRL_RIGHT_ON 0
`define CTRL_LEFT_ON 1
`define CTRL_TAB_EN 2
`define CTRL_TAB_SHIFT 3
`define CTRL_TAB_DATA 4
`define CTRL_WIDTH 5

// status field positions
`define STAT_CARRY 0
`define STAT_RIGHT_OUT 1
`define STAT_LEFT_OUT 2
`define STAT_TAB_OUT 3

// sizes and limits
`define WORD_BITS 16
`define COUNT_BITS 5
`define COUNT_MIN 5'h01
`define COUNT_MAX 5'h10
`define TAB_BITS 64
`define LEN_BITS 7
`define LEN_MIN 7'h01
`define LEN_MAX 7'h40

// reset values
`define CTRL_RST 5'h00
`define SRC_RST 16'h0000
`define COUNT_RST 5'h01
`define LEN_RST 7'h40

`endif

// ==== shifter_pkg.sv ====
package shifter_pkg;
   typedef logic [15:0] word_type;
   typedef enum logic {DIR_RIGHT, DIR_LEFT} dir_type;
endpackage : shifter_pkg

// ==== word_and_bit_table_shifter.sv ====
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "shifter_params.svh"

module word_and_bit_table_shifter (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic rightOut,
   output logic leftOut,
   output logic tableOut,
   output logic carryFlag
);
   logic [`CTRL_WIDTH-1:0] ctrl_q;
   shifter_pkg::word_type src_q;
   logic [`COUNT_BITS-1:0] count_q;
   logic [`LEN_BITS-1:0] len_q;
   shifter_pkg::word_type destR_q;
   shifter_pkg::word_type destL_q;
   logic [`TAB_BITS-1:0] tab_q;
   logic [`TAB_BITS-1:0] tab_d;
   logic [`TAB_BITS-1:0] lenMask;
   logic carry_q;
   logic carry_d;
   logic rightOut_q;
   logic leftOut_q;
   logic tabOut_q;
   logic wait_q;
   logic [31:0] readdata_q;
   logic [31:0] wdata;
   logic wrTake;
   logic scan;
   logic cntOk;
   logic lenOk;
   logic [5:0] lastIdx;
   logic lastBit;
   logic rightRun;
   logic leftRun;
   logic tabEn;
   logic tabShift;
   shifter_pkg::word_type resR;
   shifter_pkg::word_type resL;
   logic carryR;
   logic carryL;
   logic flagR;
   logic flagL;
   logic carryAfterR;
   logic carryAfterL;

   // byte-lane merge of write data
   function automatic logic [31:0] laneMerge(
      input logic [31:0] oldVal,
      input logic [31:0] newVal,
      input logic [3:0] be
   );
      logic [31:0] res;
      res = oldVal;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            res[i*8 +: 8] = newVal[i*8 +: 8];
         end
      end
      return res;
   endfunction : laneMerge

   // true when a value lies in [lo, hi]
   function automatic logic inRange(
      input logic [7:0] v,
      input logic [7:0] lo,
      input logic [7:0] hi
   );
      return (v >= lo) && (v <= hi);
   endfunction : inRange

   // one wait cycle, then one ready cycle per request
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         wait_q <= 1'b1;
      else
         wait_q <= !((read || write) && wait_q);
   end

   assign wrTake = write && !wait_q;
   assign scan = wrTake && (address == `OFS_SCAN);

   // operation controls as seen by the scan
   assign rightRun = ctrl_q[`CTRL_RIGHT_ON];
   assign leftRun = ctrl_q[`CTRL_LEFT_ON];
   assign tabEn = ctrl_q[`CTRL_TAB_EN];
   assign tabShift = ctrl_q[`CTRL_TAB_SHIFT];
   // out of range counts or lengths execute no shift; enable low still clears table and carry
   assign cntOk = inRange({3'h0, count_q}, {3'h0, `COUNT_MIN},
                          {3'h0, `COUNT_MAX});
   assign lenOk = inRange({1'h0, len_q}, {1'h0, `LEN_MIN},
                          {1'h0, `LEN_MAX});
   assign lastIdx = len_q[5:0] - 6'h01;
   assign lastBit = lenOk ? tab_q[lastIdx] : 1'b0;

   // partial-word writes keep untouched lanes; a process, so that
   // register updates seen inside readBack re-run the merge
   always_comb wdata = laneMerge(readBack(address), writedata, byteenable);

   // software registers written on the ready cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_q <= `CTRL_RST;
         src_q <= `SRC_RST;
         count_q <= `COUNT_RST;
         len_q <= `LEN_RST;
      end
      else if (wrTake)
      begin
         unique case (address)
            `OFS_CTRL: ctrl_q <= wdata[`CTRL_WIDTH-1:0];
            `OFS_SRC: src_q <= wdata[`WORD_BITS-1:0];
            `OFS_COUNT: count_q <= wdata[`COUNT_BITS-1:0];
            `OFS_LEN: len_q <= wdata[`LEN_BITS-1:0];
            default: ;
         endcase
      end
   end

   // read mux, unmapped addresses read zero
   function automatic logic [31:0] readBack(input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         `OFS_CTRL: r[`CTRL_WIDTH-1:0] = ctrl_q;
         `OFS_SRC: r[15:0] = src_q;
         `OFS_COUNT: r[`COUNT_BITS-1:0] = count_q;
         `OFS_LEN: r[`LEN_BITS-1:0] = len_q;
         `OFS_STATUS:
         begin
            r[`STAT_CARRY] = carry_q;
            r[`STAT_RIGHT_OUT] = rightOut_q;
            r[`STAT_LEFT_OUT] = leftOut_q;
            r[`STAT_TAB_OUT] = tabOut_q;
         end
         `OFS_DEST_R: r[15:0] = destR_q;
         `OFS_DEST_L: r[15:0] = destL_q;
         `OFS_TAB_LO: r = tab_q[31:0];
         `OFS_TAB_HI: r = tab_q[63:32];
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction : readBack

   // read data caught on the wait cycle, stands on the ready cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         readdata_q <= 32'h0000_0000;
      else if (read && wait_q)
         readdata_q <= readBack(address);
   end

   word_shifter #(
      .DIR(shifter_pkg::DIR_RIGHT)
   ) rightUnit (
      .src(src_q),
      .count(count_q),
      .result(resR),
      .carryOut(carryR),
      .msbLsb(flagR)
   );

   word_shifter #(
      .DIR(shifter_pkg::DIR_LEFT)
   ) leftUnit (
      .src(src_q),
      .count(count_q),
      .result(resL),
      .carryOut(carryL),
      .msbLsb(flagL)
   );

   // carry passes right, left, table in scan order
   assign carryAfterR = (rightRun && cntOk) ? carryR : carry_q;
   assign carryAfterL = (leftRun && cntOk) ? carryL : carryAfterR;

   // bits at or past the length are zeroed on each table shift
   generate
      for (genvar g = 0; g < `TAB_BITS; g++)
      begin : gMask
         assign lenMask[g] = (g < len_q);
      end
   endgenerate

   // next table: shift, hold or clear
   generate
      for (genvar g = 0; g < `TAB_BITS; g++)
      begin : gTab
         if (g == 0)
         begin : gLow
            assign tab_d[g] = !tabEn ? 1'b0 :
               (tabShift && lenOk) ? ctrl_q[`CTRL_TAB_DATA] : tab_q[g];
         end
         else
         begin : gUp
            // each bit moves one address up
            assign tab_d[g] = !tabEn ? 1'b0 :
               (tabShift && lenOk) ? (tab_q[g-1] & lenMask[g]) :
               tab_q[g];
         end
      end
   endgenerate

   // top bit leaves into carry, clears it
   assign carry_d = !tabEn ? 1'b0 :
      (tabShift && lenOk) ? lastBit : carryAfterL;

   // every scan with shift high shifts again
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tab_q <= {`TAB_BITS{1'b0}};
         carry_q <= 1'b0;
      end
      else if (scan)
      begin
         tab_q <= tab_d;
         carry_q <= carry_d;
      end
   end

   // multi-bit shift results, one per scan
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         destR_q <= `SRC_RST;
         destL_q <= `SRC_RST;
         rightOut_q <= 1'b0;
         leftOut_q <= 1'b0;
      end
      else if (scan)
      begin
         if (rightRun && cntOk)
            destR_q <= resR;
         rightOut_q <= rightRun && cntOk && flagR;
         if (leftRun && cntOk)
            destL_q <= resL;
         leftOut_q <= leftRun && cntOk && flagL;
      end
   end

   // table output follows the last bit after each scan
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         tabOut_q <= 1'b0;
      else if (scan)
      begin
         // last bit shown shift or not
         tabOut_q <= tabEn && lenOk && tab_d[lastIdx];
      end
   end

   assign readdata = readdata_q;
   assign waitrequest = wait_q;
   assign rightOut = rightOut_q;
   assign leftOut = leftOut_q;
   assign tableOut = tabOut_q;
   assign carryFlag = carry_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence scanRight;
      scan && rightRun && cntOk;
   endsequence

   sequence scanLeft;
      scan && leftRun && cntOk;
   endsequence

   sequence scanTabShift;
      scan && tabEn && tabShift && lenOk;
   endsequence

   a_bus_ready_once: assert property (
      (read || write) && wait_q |=> !wait_q ##1 wait_q)
      else $error("waitrequest did not drop for one cycle");

   a_right_result: assert property (
      scanRight |=> destR_q == ($past(src_q) >> $past(count_q)))
      else $error("right shift result wrong");

   a_right_fill_zero: assert property (
      scanRight |=>
      ({16'h0000, destR_q} >> (6'h10 - $past(count_q))) == 32'h0)
      else $error("right shift upper bits not zero");

   a_right_out_lsb: assert property (
      scanRight |=> rightOut_q == destR_q[0])
      else $error("right output not from lsb");

   a_left_result: assert property (
      scanLeft |=> destL_q == 16'($past(src_q) << $past(count_q)))
      else $error("left shift result wrong");

   a_left_fill_zero: assert property (
      scanLeft |=>
      (destL_q & 16'((17'h1 << $past(count_q)) - 17'h1)) == 16'h0)
      else $error("left shift lower bits not zero");

   a_left_out_msb: assert property (
      scanLeft |=> leftOut_q == destL_q[15])
      else $error("left output not from msb");

   a_tab_move_up: assert property (
      scanTabShift |=>
      (tab_q[63:1] & lenMask[63:1]) == ($past(tab_q[62:0]) & lenMask[63:1]))
      else $error("table did not move up");

   a_tab_load_low: assert property (
      scanTabShift |=> tab_q[0] == $past(ctrl_q[`CTRL_TAB_DATA]))
      else $error("table low bit not loaded");

   a_tab_carry_out: assert property (
      scanTabShift |=> carry_q == $past(lastBit))
      else $error("carry not from table top");

   a_tab_clear: assert property (
      scan && !tabEn |=> tab_q == 64'h0 && !carry_q ##1 !tableOut)
      else $error("disabled table not cleared");

   a_tab_out_low: assert property (
      scan && !tabEn |=> !tableOut)
      else $error("disabled table output high");

   a_tab_out_last: assert property (
      scan && tabEn && lenOk |=> tableOut == tab_q[lastIdx])
      else $error("table output not last bit");

   a_tab_hold: assert property (
      scan && tabEn && !tabShift |=> $stable(tab_q))
      else $error("table changed without shift");

   a_right_off: assert property (
      scan && !rightRun |=> !rightOut_q && $stable(destR_q))
      else $error("idle right shift acted");
endmodule : word_and_bit_table_shifter
`default_nettype wire

// ==== word_and_bit_table_shifter_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "shifter_params.svh"

module word_and_bit_table_shifter_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] writedata = 32'h0000_0000;
   logic [31:0] readdata;
   logic waitrequest;
   logic rightOut;
   logic leftOut;
   logic tableOut;
   logic carryFlag;
   int errorCnt = 0;
   int checks = 0;
   logic [31:0] q;
   logic [15:0] src;
   logic [15:0] res;
   logic [63:0] tm;
   logic cm;

   // 200 MHz scan clock
   always #2.5 clk = ~clk;

   word_and_bit_table_shifter dut (
      .clk(clk), .rst(rst), .address(address), .read(read),
      .write(write), .byteenable(byteenable), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest),
      .rightOut(rightOut), .leftOut(leftOut), .tableOut(tableOut),
      .carryFlag(carryFlag));

   // counts, verdict, end of run
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, errorCnt);
      if (errorCnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   // one bus cycle; starts an edge after the last release so a strobe
   // is never lowered and raised in the same time step
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [31:0] d, input logic [3:0] be);
      int n;
      @(posedge clk);
      address <= a;
      write <= wr;
      read <= ~wr;
      writedata <= d;
      byteenable <= be;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 40);
      if (waitrequest !== 1'b0)
      begin
         errorCnt++;
         $display("BAD %0t wait %h exp %h", $time, waitrequest, 1'b0);
         conclude();
      end
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask : wr

   // word compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // pin compare
   task automatic chkBit(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chkBit

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, 4'hF);
      chk(q, exp);
   endtask : rdChk

   // one word shift; table kept enabled without shift so that
   // the table part cannot touch the carry
   task automatic wordOp(input logic left, input int n);
      logic c;
      logic o;
      wr(`OFS_COUNT, 32'(n));
      wr(`OFS_CTRL, left ? 32'h0000_0006 : 32'h0000_0005);
      wr(`OFS_SCAN, 32'h0000_0000);
      res = left ? src << n : src >> n;
      c = left ? src[16 - n] : src[n - 1];
      o = left ? res[15] : res[0];
      rdChk(left ? `OFS_DEST_L : `OFS_DEST_R, {16'h0000, res}); // word
      rdChk(`OFS_STATUS, 32'({1'b0, left & o, ~left & o, c})); // status
      chkBit(carryFlag, c); // last bit out
      chkBit(left ? leftOut : rightOut, o); // output pin
   endtask : wordOp

   // one table scan with shift on, model kept alongside
   task automatic tabScan(input int len, input logic d);
      wr(`OFS_CTRL, d ? 32'h0000_001C : 32'h0000_000C);
      wr(`OFS_SCAN, 32'h0000_0000);
      cm = tm[len - 1];
      tm = (tm << 1) | 64'(d);
      if (len < 64)
         tm = tm & ((64'h1 << len) - 64'h1);
      rdChk(`OFS_TAB_LO, tm[31:0]); // low half
      rdChk(`OFS_TAB_HI, tm[63:32]); // high half
      chkBit(tableOut, tm[len - 1]); // last bit shown
      chkBit(carryFlag, cm); // top bit to carry
   endtask : tabScan

   // enable low at a scan wipes the table
   task automatic clearTab;
      wr(`OFS_CTRL, 32'h0000_0010);
      wr(`OFS_SCAN, 32'h0000_0000);
      tm = 64'h0;
      rdChk(`OFS_TAB_LO, 32'h0000_0000); // table cleared
      rdChk(`OFS_TAB_HI, 32'h0000_0000); // table cleared
      chkBit(tableOut, 1'b0); // output held low
      chkBit(carryFlag, 1'b0); // carry cleared
   endtask : clearTab

   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      // defaults, unmapped place, byte lanes, read-only target
      rdChk(`OFS_CTRL, 32'h0000_0000);
      rdChk(`OFS_COUNT, 32'h0000_0001);
      rdChk(`OFS_LEN, 32'h0000_0040);
      rdChk(8'h30, 32'h0000_0000);
      src = 16'hB6D5;
      wr(`OFS_SRC, 32'h0000_B6D5);
      bus(1'b1, `OFS_SRC, 32'h0000_FF00, 4'h1);
      rdChk(`OFS_SRC, 32'h0000_B600);
      wr(`OFS_DEST_R, 32'h0000_FFFF);
      rdChk(`OFS_DEST_R, 32'h0000_0000);
      wr(`OFS_SRC, 32'h0000_B6D5);
      $display("test registers done");
      for (int n = 1; n <= 16; n++)
      begin
         wordOp(1'b0, n); // right shift
         wordOp(1'b1, n); // left shift
      end
      $display("test word shifts done");
      wordOp(1'b1, 3); // left shift
      wordOp(1'b0, 7); // right shift
      wr(`OFS_SRC, 32'h0000_0000);
      wr(`OFS_CTRL, 32'h0000_0004);
      wr(`OFS_SCAN, 32'h0000_0000);
      rdChk(`OFS_DEST_R, 32'h0000_016D); // right word kept
      rdChk(`OFS_DEST_L, 32'h0000_B6A8); // left word kept
      chkBit(rightOut, 1'b0); // output low
      chkBit(leftOut, 1'b0); // output low
      chkBit(carryFlag, 1'b1); // carry kept
      wr(`OFS_COUNT, 32'h0000_0000);
      wr(`OFS_CTRL, 32'h0000_0007);
      wr(`OFS_SCAN, 32'h0000_0000);
      rdChk(`OFS_DEST_R, 32'h0000_016D); // count zero ignored
      rdChk(`OFS_DEST_L, 32'h0000_B6A8); // count zero ignored
      chkBit(rightOut, 1'b0); // no execution output low
      chkBit(leftOut, 1'b0); // no execution output low
      chkBit(carryFlag, 1'b1); // carry kept
      $display("test operation off done");
      // shift held high shifts every scan
      wr(`OFS_LEN, 32'h0000_0005);
      tm = 64'h0;
      for (int i = 0; i < 7; i++)
         tabScan(5, 1'((8'hB6 >> i) & 8'h01)); // one shift per scan
      wr(`OFS_CTRL, 32'h0000_0014);
      wr(`OFS_SCAN, 32'h0000_0000);
      rdChk(`OFS_TAB_LO, tm[31:0]); // table unchanged
      chkBit(tableOut, tm[4]); // output without shift
      chkBit(carryFlag, cm); // carry unchanged
      clearTab(); // enable low
      $display("test short table done");
      // longest table, carry on the 65th shift
      wr(`OFS_LEN, 32'h0000_0040);
      for (int i = 0; i < 65; i++)
         tabScan(64, 1'b1); // full length
      clearTab(); // enable low
      wr(`OFS_LEN, 32'h0000_0001);
      tabScan(1, 1'b1); // data into first bit
      tabScan(1, 1'b0); // single bit to carry
      $display("test long and short tables done");
      conclude();
   end
endmodule : word_and_bit_table_shifter_tb
`default_nettype wire

// ==== word_shifter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "shifter_params.svh"

// combinational multi-bit shift through carry
module word_shifter #(
   parameter shifter_pkg::dir_type DIR = shifter_pkg::DIR_RIGHT
) (
   input wire shifter_pkg::word_type src,
   input wire logic [`COUNT_BITS-1:0] count,
   output shifter_pkg::word_type result,
   output logic carryOut,
   output logic msbLsb
);
   logic [31:0] wide;
   logic [4:0] outIdx;

   // shift in a 32 bit field so a count of 16 is still exact
   always_comb
   begin
      wide = 32'h0000_0000;
      outIdx = 5'h00;
      if (DIR == shifter_pkg::DIR_RIGHT)
      begin
         // last bit out is bit count-1
         wide = {16'h0000, src} >> count;
         outIdx = count - 5'h01;
         carryOut = src[outIdx[3:0]];
         result = wide[15:0];
         msbLsb = wide[0];
      end
      else
      begin
         // last bit out is bit 16-count
         wide = {16'h0000, src} << count;
         outIdx = 5'h10 - count;
         carryOut = src[outIdx[3:0]];
         result = wide[15:0];
         msbLsb = wide[15];
      end
   end
endmodule : word_shifter
`default_nettype wire
